// ===== pad_owner_config.sv
// Shared pad ring owner selection, electrical options, power gating and reset pins
`timescale 1ns/1ns
// Overview of operation
// RULE1: each shared pad is driven by one subsystem chosen by its owner field
// RULE2: secure and high-performance pads work only in the two top power states
// RULE3: low-power domain pads work in every power state except the sleep states
// RULE4: battery-domain pads stay usable in every power state, sleep included
// RULE5: each shared pad has a two-bit drive strength field for 2, 4, 8, 12 mA
// RULE6: each shared pad has a slow or fast slew selection bit
// RULE7: open-drain pads drive a fixed low and use output enable as the data
// RULE8: each shared pad selects pull-up, pull-down, keeper or plain input
// RULE9: each shared pad input has a hysteresis enable bit
// RULE10: shared pads float when core power is bad, in reset, or in deep sleep
// RULE11: battery-domain pads offer only direction and I/O voltage selection
// RULE12: the reset pin resets digital logic only, never the analog side
// RULE13: the device pulls the reset pin low while power-ok input is low
// RULE14: the outside holds power-ok input low until the supplies are valid
// RULE15: power-ok output starts low and rises once both supplies are valid
// RULE16: three low-power pads carry antenna select when the external switch is set
// RULE17: non-owners are ignored and every subsystem sees the pad input values
module pad_owner_config (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Subsystem pad requests and returned pad values
	input wire pad_pkg::subsys_drive_type secure_zone_cpu,
	input wire pad_pkg::subsys_drive_type high_perf_mcu_domain,
	input wire pad_pkg::subsys_drive_type low_power_mcu_domain,
	output logic [7:0] pad_in_to_subsys,
	// Power manager and radio
	input wire pad_pkg::power_state_type power_state,
	input wire logic [2:0] antenna_select,
	// Shared pads
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe,
	output pad_pkg::pad_elec_type [7:0] pad_elec,
	// Battery-domain pads
	input wire logic [1:0] aon_drive_data,
	input wire logic [1:0] aon_pad_in,
	output logic [1:0] aon_pad_out,
	output logic [1:0] aon_pad_oe,
	output logic [1:0] aon_pad_vsel,
	// Supply monitors, power-on control and reset pin
	input wire logic core_power_valid,
	input wire logic aon_supply_valid,
	input wire logic scdc_supply_valid,
	input wire logic power_ok_in,
	output logic power_ok_out,
	input wire logic reset_pad_in,
	output logic reset_pad_out,
	output logic reset_pad_oe,
	output logic digital_rst,
	output logic analog_rst
);

	pad_pkg::pad_cfg_type cfg_reg [8];
	logic [1:0] aon_dir_reg;
	logic [1:0] aon_vsel_reg;
	logic antenna_ext_reg;

	logic [14:0] sync_in;
	logic [14:0] sync_q;
	logic [7:0] pad_in_s;
	logic [1:0] aon_in_s;
	logic core_s;
	logic aon_ok_s;
	logic scdc_ok_s;
	logic poc_s;
	logic reset_pin_s;

	logic pads_off;
	logic [7:0] avail_next;
	logic [7:0] pad_out_next;
	logic [7:0] pad_oe_next;
	logic [31:0] rdata_next;

	// Owner-based availability against the current power state
	function automatic logic owner_ok(input pad_pkg::owner_type owner, input pad_pkg::power_state_type ps);
		logic top_two;
		logic awake;
		top_two = (ps == pad_pkg::POWER_STATE_TOP) || (ps == pad_pkg::POWER_STATE_HIGH);
		awake = top_two || (ps == pad_pkg::POWER_STATE_MID) || (ps == pad_pkg::POWER_STATE_LOW);
		unique case (owner)
			pad_pkg::OWN_SECURE: owner_ok = top_two; // RULE2
			pad_pkg::OWN_HIGH_PERF: owner_ok = top_two; // RULE2
			pad_pkg::OWN_LOW_POWER: owner_ok = awake; // RULE3
			pad_pkg::OWN_NONE: owner_ok = 1'b0;
		endcase
	endfunction

	function automatic logic is_pad_addr(input logic [7:0] addr);
		is_pad_addr = (addr[7:5] == pad_pkg::OFF_PAD_CFG[7:5]) && (addr[1:0] == 2'h0);
	endfunction

	function automatic pad_pkg::pad_cfg_type cfg_from_word(input logic [31:0] w);
		pad_pkg::pad_cfg_type c;
		c.owner = pad_pkg::owner_type'(w[pad_pkg::CFG_OWNER_POS +: 2]);
		c.elec.drive_sel = w[pad_pkg::CFG_DRIVE_POS +: 2];
		c.elec.slew_fast = w[pad_pkg::CFG_SLEW_POS];
		c.open_drain = w[pad_pkg::CFG_OD_POS];
		c.elec.pull_sel = pad_pkg::pull_type'(w[pad_pkg::CFG_PULL_POS +: 2]);
		c.elec.hyst_en = w[pad_pkg::CFG_HYST_POS];
		return c;
	endfunction

	function automatic logic [31:0] cfg_to_word(input pad_pkg::pad_cfg_type c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[pad_pkg::CFG_OWNER_POS +: 2] = c.owner;
		w[pad_pkg::CFG_DRIVE_POS +: 2] = c.elec.drive_sel;
		w[pad_pkg::CFG_SLEW_POS] = c.elec.slew_fast;
		w[pad_pkg::CFG_OD_POS] = c.open_drain;
		w[pad_pkg::CFG_PULL_POS +: 2] = c.elec.pull_sel;
		w[pad_pkg::CFG_HYST_POS] = c.elec.hyst_en;
		return w;
	endfunction

	// Every level from a pin or an analog monitor crosses into clk here
	assign sync_in = {reset_pad_in, power_ok_in, scdc_supply_valid, aon_supply_valid, core_power_valid,
		aon_pad_in, pad_in};

	pin_sync #(
		.W(pad_pkg::SYNC_W),
		.RESET_VAL(pad_pkg::SYNC_RESET)
	) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.async_in(sync_in),
		.sync_out(sync_q)
	);

	assign pad_in_s = sync_q[7:0];
	assign aon_in_s = sync_q[9:8];
	assign core_s = sync_q[10];
	assign aon_ok_s = sync_q[11];
	assign scdc_ok_s = sync_q[12];
	assign poc_s = sync_q[13];
	assign reset_pin_s = sync_q[14];

	// Software writes
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < pad_pkg::NUM_PADS; i++) begin
				cfg_reg[i] <= pad_pkg::CFG_RESET;
			end
		end else if (reg_wr && is_pad_addr(reg_addr)) begin
			cfg_reg[reg_addr[4:2]] <= cfg_from_word(reg_wdata); // RULE1 RULE5 RULE6 RULE8 RULE9
		end
	end

	// Battery pads carry only direction and voltage selection
	always_ff @(posedge clk) begin
		if (rst) begin
			aon_dir_reg <= pad_pkg::AON_DIR_RESET;
			aon_vsel_reg <= pad_pkg::AON_VSEL_RESET;
		end else if (reg_wr && reg_addr == pad_pkg::OFF_AON_CFG) begin
			aon_dir_reg <= reg_wdata[pad_pkg::AON_DIR_POS +: 2]; // RULE11
			aon_vsel_reg <= reg_wdata[pad_pkg::AON_VSEL_POS +: 2]; // RULE11
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			antenna_ext_reg <= 1'b0;
		end else if (reg_wr && reg_addr == pad_pkg::OFF_CTRL) begin
			antenna_ext_reg <= reg_wdata[pad_pkg::CTRL_ANT_POS];
		end
	end

	// Deep sleep, bad core supply and held reset all float the shared ring
	assign pads_off = !core_s || digital_rst || (power_state == pad_pkg::POWER_STATE_DEEP); // RULE10

	always_comb begin
		logic [1:0] ant_idx;
		logic sel_out;
		logic sel_oe;
		ant_idx = 2'h0;
		sel_out = 1'b0;
		sel_oe = 1'b0;
		for (int i = 0; i < pad_pkg::NUM_PADS; i++) begin
			unique case (cfg_reg[i].owner)
				pad_pkg::OWN_SECURE: begin
					sel_out = secure_zone_cpu.out[i]; // RULE1 RULE17
					sel_oe = secure_zone_cpu.oe[i];
				end
				pad_pkg::OWN_HIGH_PERF: begin
					sel_out = high_perf_mcu_domain.out[i]; // RULE1 RULE17
					sel_oe = high_perf_mcu_domain.oe[i];
				end
				pad_pkg::OWN_LOW_POWER: begin
					sel_out = low_power_mcu_domain.out[i]; // RULE1 RULE17
					sel_oe = low_power_mcu_domain.oe[i];
				end
				pad_pkg::OWN_NONE: begin
					sel_out = 1'b0;
					sel_oe = 1'b0;
				end
			endcase
			avail_next[i] = owner_ok(cfg_reg[i].owner, power_state);
			if (antenna_ext_reg && pad_pkg::ANT_PAD_MASK[i]) begin
				// Radio takes the pad over, still bound to low-power availability
				sel_out = antenna_select[ant_idx]; // RULE16
				sel_oe = 1'b1;
				avail_next[i] = owner_ok(pad_pkg::OWN_LOW_POWER, power_state); // RULE16
				ant_idx = ant_idx + 2'h1;
			end else if (pad_pkg::ANT_PAD_MASK[i]) begin
				ant_idx = ant_idx + 2'h1;
			end
			if (cfg_reg[i].open_drain) begin
				pad_out_next[i] = 1'b0; // RULE7
				pad_oe_next[i] = sel_oe; // RULE7
			end else begin
				pad_out_next[i] = sel_out;
				pad_oe_next[i] = sel_oe;
			end
			if (!avail_next[i] || pads_off) begin
				pad_oe_next[i] = 1'b0; // RULE2 RULE3 RULE10
				pad_out_next[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pad_out <= 8'h00;
			pad_oe <= 8'h00;
		end else begin
			pad_out <= pad_out_next;
			pad_oe <= pad_oe_next;
		end
	end

	// Electrical options follow the register even while the pad floats
	always_ff @(posedge clk) begin
		if (rst) begin
			pad_elec <= {pad_pkg::NUM_PADS{pad_pkg::CFG_RESET.elec}};
		end else begin
			for (int i = 0; i < pad_pkg::NUM_PADS; i++) begin
				pad_elec[i] <= cfg_reg[i].elec; // RULE5 RULE6 RULE8 RULE9
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pad_in_to_subsys <= 8'h00;
		end else begin
			pad_in_to_subsys <= pad_in_s; // RULE17
		end
	end

	// Battery pads ignore power state and core supply
	always_ff @(posedge clk) begin
		if (rst) begin
			aon_pad_out <= 2'h0;
			aon_pad_oe <= 2'h0;
			aon_pad_vsel <= 2'h0;
		end else begin
			aon_pad_out <= aon_drive_data & aon_dir_reg; // RULE4
			aon_pad_oe <= aon_dir_reg; // RULE4 RULE11
			aon_pad_vsel <= aon_vsel_reg; // RULE11
		end
	end

	// Reset pin and power-on control
	always_ff @(posedge clk) begin
		if (rst) begin
			digital_rst <= 1'b1;
			analog_rst <= 1'b1;
			reset_pad_out <= 1'b0;
			reset_pad_oe <= 1'b0;
			power_ok_out <= 1'b0;
		end else begin
			digital_rst <= !poc_s || !reset_pin_s; // RULE12 RULE14
			analog_rst <= !poc_s; // RULE12 RULE14
			reset_pad_out <= 1'b0;
			reset_pad_oe <= !poc_s; // RULE13
			power_ok_out <= aon_ok_s && scdc_ok_s; // RULE15
		end
	end

	// Register reads answer in the following cycle; unmapped addresses read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (is_pad_addr(reg_addr)) begin
			rdata_next = cfg_to_word(cfg_reg[reg_addr[4:2]]);
		end else if (reg_addr == pad_pkg::OFF_AON_CFG) begin
			rdata_next[pad_pkg::AON_DIR_POS +: 2] = aon_dir_reg;
			rdata_next[pad_pkg::AON_VSEL_POS +: 2] = aon_vsel_reg;
		end else if (reg_addr == pad_pkg::OFF_CTRL) begin
			rdata_next[pad_pkg::CTRL_ANT_POS] = antenna_ext_reg;
		end else if (reg_addr == pad_pkg::OFF_STATUS) begin
			rdata_next[pad_pkg::STAT_AVAIL_POS +: 8] = avail_next & {8{!pads_off}};
			rdata_next[pad_pkg::STAT_PADIN_POS +: 8] = pad_in_s;
			rdata_next[pad_pkg::STAT_AONIN_POS +: 2] = aon_in_s;
			rdata_next[pad_pkg::STAT_POK_POS] = power_ok_out;
			rdata_next[pad_pkg::STAT_CORE_POS] = core_s;
			rdata_next[pad_pkg::STAT_DRST_POS] = digital_rst;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	owner_select_a: assert property ( // RULE1
		(cfg_reg[3].owner == pad_pkg::OWN_SECURE && !cfg_reg[3].open_drain && avail_next[3] && !pads_off)
		|=> pad_out[3] == $past(secure_zone_cpu.out[3]) && pad_oe[3] == $past(secure_zone_cpu.oe[3]))
		else $error("pad 3 does not follow its secure owner");
	high_perf_gate_a: assert property ( // RULE2
		(cfg_reg[1].owner == pad_pkg::OWN_HIGH_PERF && power_state != pad_pkg::POWER_STATE_TOP
		&& power_state != pad_pkg::POWER_STATE_HIGH) |=> !pad_oe[1])
		else $error("high-performance pad driven outside top states");
	low_power_sleep_a: assert property ( // RULE3
		(cfg_reg[2].owner == pad_pkg::OWN_LOW_POWER && power_state == pad_pkg::POWER_STATE_SLEEP) |=> !pad_oe[2])
		else $error("low-power pad driven in sleep");
	low_power_awake_a: assert property ( // RULE3
		(cfg_reg[2].owner == pad_pkg::OWN_LOW_POWER && power_state == pad_pkg::POWER_STATE_LOW && !pads_off
		&& !cfg_reg[2].open_drain && low_power_mcu_domain.oe[2]) |=> pad_oe[2])
		else $error("low-power pad not driven in low state");
	battery_alive_a: assert property ( // RULE4
		(power_state == pad_pkg::POWER_STATE_DEEP) [*2] |-> aon_pad_oe == $past(aon_dir_reg))
		else $error("battery pad direction lost in deep sleep");
	drive_field_a: assert property ( // RULE5
		##1 pad_elec[0].drive_sel == $past(cfg_reg[0].elec.drive_sel))
		else $error("drive strength not applied");
	slew_field_a: assert property ( // RULE6
		$changed(cfg_reg[5].elec.slew_fast) |=> pad_elec[5].slew_fast == $past(cfg_reg[5].elec.slew_fast))
		else $error("slew setting not applied");
	open_drain_low_a: assert property ( // RULE7
		cfg_reg[4].open_drain && !(antenna_ext_reg && pad_pkg::ANT_PAD_MASK[4]) |=> !pad_out[4])
		else $error("open-drain pad drives high");
	pull_field_a: assert property ( // RULE8
		$changed(cfg_reg[6].elec.pull_sel) |=> pad_elec[6].pull_sel == $past(cfg_reg[6].elec.pull_sel))
		else $error("pull option not applied");
	hyst_field_a: assert property ( // RULE9
		$changed(cfg_reg[7].elec.hyst_en) |=> pad_elec[7].hyst_en == $past(cfg_reg[7].elec.hyst_en))
		else $error("hysteresis option not applied");
	tristate_hold_a: assert property ( // RULE10
		(!core_s || digital_rst || power_state == pad_pkg::POWER_STATE_DEEP) |=> pad_oe == 8'h00)
		else $error("shared pad driven while ring must float");
	digital_only_a: assert property ( // RULE12
		(poc_s && !reset_pin_s) |=> digital_rst && !analog_rst)
		else $error("reset pin reached analog side or missed digital side");
	reset_pull_a: assert property ( // RULE13
		!poc_s |=> reset_pad_oe && !reset_pad_out)
		else $error("reset pin not pulled low");
	power_ok_a: assert property ( // RULE15
		$rose(power_ok_out) |-> $past(aon_ok_s) && $past(scdc_ok_s))
		else $error("power-ok output rose without both supplies");
	antenna_pad_a: assert property ( // RULE16
		(antenna_ext_reg && !pads_off && owner_ok(pad_pkg::OWN_LOW_POWER, power_state))
		|=> pad_oe[0] && pad_out[0] == $past(antenna_select[0]) && pad_out[5] == $past(antenna_select[2]))
		else $error("antenna select not on its pads");

	cover_owner_switch: cover property ($changed(cfg_reg[0].owner) ##1 pad_oe[0]);
	cover_deep_sleep: cover property (pad_oe != 8'h00 ##1 power_state == pad_pkg::POWER_STATE_DEEP ##1 pad_oe == 8'h00);
	cover_antenna: cover property (antenna_ext_reg && pad_oe[4]);
	cover_power_ok: cover property ($rose(power_ok_out));

endmodule

// ===== pad_pkg.sv
// Shared constants, field layouts and types of the pad owner and configuration block
package pad_pkg;

	localparam int NUM_PADS = 8;
	localparam int NUM_AON = 2;

	// Register byte addresses
	localparam logic [7:0] OFF_PAD_CFG = 8'h00;
	localparam logic [7:0] OFF_AON_CFG = 8'h20;
	localparam logic [7:0] OFF_CTRL = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;

	// Pad configuration word fields
	localparam int CFG_OWNER_POS = 0;
	localparam int CFG_DRIVE_POS = 2;
	localparam int CFG_SLEW_POS = 4;
	localparam int CFG_OD_POS = 5;
	localparam int CFG_PULL_POS = 6;
	localparam int CFG_HYST_POS = 8;

	// Battery-domain configuration word fields
	localparam int AON_DIR_POS = 0;
	localparam int AON_VSEL_POS = 2;

	// Control and status word fields
	localparam int CTRL_ANT_POS = 0;
	localparam int STAT_AVAIL_POS = 0;
	localparam int STAT_PADIN_POS = 8;
	localparam int STAT_AONIN_POS = 16;
	localparam int STAT_POK_POS = 18;
	localparam int STAT_CORE_POS = 19;
	localparam int STAT_DRST_POS = 20;

	// Pads that carry antenna select when an external RF switch is fitted
	localparam logic [7:0] ANT_PAD_MASK = 8'h31;

	// Synchroniser lane layout and reset levels
	localparam int SYNC_W = 15;
	localparam logic [14:0] SYNC_RESET = 15'h4000;

	typedef enum logic [1:0] {
		OWN_SECURE = 2'h0,
		OWN_HIGH_PERF = 2'h1,
		OWN_LOW_POWER = 2'h2,
		OWN_NONE = 2'h3
	} owner_type;

	typedef enum logic [1:0] {
		PULL_PLAIN = 2'h0,
		PULL_UP = 2'h1,
		PULL_DOWN = 2'h2,
		PULL_KEEPER = 2'h3
	} pull_type;

	typedef enum logic [5:0] {
		POWER_STATE_TOP = 6'h01,
		POWER_STATE_HIGH = 6'h02,
		POWER_STATE_MID = 6'h04,
		POWER_STATE_LOW = 6'h08,
		POWER_STATE_SLEEP = 6'h10,
		POWER_STATE_DEEP = 6'h20
	} power_state_type;

	typedef struct packed {
		logic [1:0] drive_sel;
		logic slew_fast;
		pull_type pull_sel;
		logic hyst_en;
	} pad_elec_type;

	typedef struct packed {
		owner_type owner;
		logic open_drain;
		pad_elec_type elec;
	} pad_cfg_type;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} subsys_drive_type;

	localparam pad_cfg_type CFG_RESET = '{owner: OWN_LOW_POWER, open_drain: 1'b0,
		elec: '{drive_sel: 2'h0, slew_fast: 1'b0, pull_sel: PULL_PLAIN, hyst_en: 1'b0}};
	localparam logic [1:0] AON_DIR_RESET = 2'h0;
	localparam logic [1:0] AON_VSEL_RESET = 2'h0;

endpackage

// ===== pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Lanes
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;
	logic [W-1:0] stage3_reg;

	// Stage one feeds stage two only, so no logic sees a metastable level
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1_reg <= RESET_VAL;
			stage2_reg <= RESET_VAL;
			stage3_reg <= RESET_VAL;
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_out <= RESET_VAL;
		end else begin
			sync_out <= (stage2_reg & stage3_reg) | (sync_out & (stage2_reg | stage3_reg));
		end
	end

endmodule

// ===== tb_top.sv
// Self-checking bench for the pad owner and configuration block
`timescale 1ns/1ns
module tb_top;
	localparam pad_pkg::subsys_drive_type DRV_ON = '{out: 8'hFF, oe: 8'hFF};
	localparam pad_pkg::subsys_drive_type DRV_OFF = '{out: 8'h00, oe: 8'hFF};
	localparam pad_pkg::subsys_drive_type DRV_IDLE = '{out: 8'h00, oe: 8'h00};
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	pad_pkg::subsys_drive_type sz_drv = DRV_IDLE;
	pad_pkg::subsys_drive_type hp_drv = DRV_IDLE;
	pad_pkg::subsys_drive_type lp_drv = DRV_IDLE;
	logic [7:0] pad_in_to_subsys;
	pad_pkg::power_state_type power_state = pad_pkg::POWER_STATE_TOP;
	logic [2:0] antenna_select = 3'h0;
	logic [7:0] pad_in = 8'h00;
	logic [7:0] pad_out;
	logic [7:0] pad_oe;
	pad_pkg::pad_elec_type [7:0] pad_elec;
	logic [1:0] aon_drive_data = 2'h0;
	logic [1:0] aon_pad_out;
	logic [1:0] aon_pad_oe;
	logic [1:0] aon_pad_vsel;
	logic core_ok = 1'h1;
	logic aon_ok = 1'h1;
	logic scdc_ok = 1'h1;
	logic pok_in = 1'h0;
	logic rst_pin_drv = 1'h1;
	logic rst_pin;
	logic power_ok_out;
	logic reset_pad_out;
	logic reset_pad_oe;
	logic digital_rst;
	logic analog_rst;
	logic [31:0] rdv;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	pad_pkg::power_state_type st_tab [6] = '{pad_pkg::POWER_STATE_TOP, pad_pkg::POWER_STATE_HIGH,
		pad_pkg::POWER_STATE_MID, pad_pkg::POWER_STATE_LOW, pad_pkg::POWER_STATE_SLEEP, pad_pkg::POWER_STATE_DEEP};
	logic sec_tab [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
	logic low_tab [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};

	// Reset pin is open drain with a pull-up: the device only ever pulls it low
	assign rst_pin = reset_pad_oe ? 1'h0 : rst_pin_drv;

	always #4 clk = ~clk;

	pad_owner_config DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .secure_zone_cpu(sz_drv), .high_perf_mcu_domain(hp_drv),
		.low_power_mcu_domain(lp_drv), .pad_in_to_subsys(pad_in_to_subsys), .power_state(power_state),
		.antenna_select(antenna_select), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_elec(pad_elec), .aon_drive_data(aon_drive_data), .aon_pad_in(2'h2), .aon_pad_out(aon_pad_out),
		.aon_pad_oe(aon_pad_oe), .aon_pad_vsel(aon_pad_vsel), .core_power_valid(core_ok),
		.aon_supply_valid(aon_ok), .scdc_supply_valid(scdc_ok), .power_ok_in(pok_in),
		.power_ok_out(power_ok_out), .reset_pad_in(rst_pin), .reset_pad_out(reset_pad_out),
		.reset_pad_oe(reset_pad_oe), .digital_rst(digital_rst), .analog_rst(analog_rst));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
		// Read data stands for one cycle only
		@(posedge clk);
		#1;
		chk("rdata idle", 32'h0000_0000, reg_rdata);
	endtask

	// Async monitors need three synchroniser stages, the synchroniser output and the output register
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [31:0] cfg(input logic [1:0] own, input logic [1:0] drv, input logic sl,
		input logic od, input logic [1:0] pl, input logic hy);
		return (32'(own) << pad_pkg::CFG_OWNER_POS) | (32'(drv) << pad_pkg::CFG_DRIVE_POS)
			| (32'(sl) << pad_pkg::CFG_SLEW_POS) | (32'(od) << pad_pkg::CFG_OD_POS)
			| (32'(pl) << pad_pkg::CFG_PULL_POS) | (32'(hy) << pad_pkg::CFG_HYST_POS);
	endfunction

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			$display("unexpected timeout: expected end seen hang");
			complete_run();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		pok_in <= 1'h1;
		settle(6);
		rd(pad_pkg::OFF_PAD_CFG + 8'h04, rdv);
		chk("pad cfg reset", 32'h0000_0002, rdv);
		rd(pad_pkg::OFF_AON_CFG, rdv);
		chk("aon cfg reset", 32'h0000_0000, rdv);
		rd(pad_pkg::OFF_CTRL, rdv);
		chk("ctrl reset", 32'h0000_0000, rdv);
		rd(8'h2C, rdv);
		chk("unmapped read", 32'h0000_0000, rdv);
		chk("power ok out", 32'h0000_0001, 32'(power_ok_out));
		chk("digital reset", 32'h0000_0000, 32'(digital_rst));
		chk("reset pin pull", 32'h0000_0000, 32'(reset_pad_oe));
		$display("test reset done");

		@(posedge clk);
		pad_in <= 8'hA5;
		for (int o = 0; o < 4; o++) begin
			@(posedge clk);
			sz_drv <= (o == 0) ? DRV_ON : DRV_OFF;
			hp_drv <= (o == 1) ? DRV_ON : DRV_OFF;
			lp_drv <= (o == 2) ? DRV_ON : DRV_OFF;
			wr(pad_pkg::OFF_PAD_CFG + 8'h0C, cfg(2'(o), 2'h0, 1'h0, 1'h0, 2'h0, 1'h0));
			settle(3);
			chk("pad3 out", (o < 3) ? 32'h1 : 32'h0, 32'(pad_out[3]));
			chk("pad3 oe", (o < 3) ? 32'h1 : 32'h0, 32'(pad_oe[3]));
		end
		chk("pad in to subsys", 32'h0000_00A5, 32'(pad_in_to_subsys));
		$display("test owner done");

		wr(pad_pkg::OFF_PAD_CFG + 8'h0C, cfg(2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0));
		wr(pad_pkg::OFF_AON_CFG, 32'h0000_000B);
		wr(pad_pkg::OFF_PAD_CFG + 8'h04, cfg(2'h1, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0));
		@(posedge clk);
		sz_drv <= DRV_ON;
		hp_drv <= DRV_ON;
		aon_drive_data <= 2'h1;
		for (int s = 0; s < 6; s++) begin
			@(posedge clk);
			power_state <= st_tab[s];
			settle(3);
			rd(pad_pkg::OFF_STATUS, rdv);
			chk("avail low", low_tab[s] ? 32'hF5 : 32'h0, rdv[7:0] & 8'hF5);
			chk("avail secure", 32'(sec_tab[s]), 32'(rdv[3]));
			chk("secure oe", 32'(sec_tab[s]), 32'(pad_oe[3]));
			chk("high perf oe", 32'(sec_tab[s]), 32'(pad_oe[1]));
			chk("status inputs", 32'h0000_02A5, 32'(rdv[17:8]));
			chk("aon out", 32'h0000_0001, 32'(aon_pad_out));
			chk("aon oe", 32'h0000_0003, 32'(aon_pad_oe));
		end
		chk("deep sleep oe", 32'h0000_0000, 32'(pad_oe));
		$display("test power state done");

		@(posedge clk);
		power_state <= pad_pkg::POWER_STATE_TOP;
		core_ok <= 1'h0;
		settle(6);
		chk("core off oe", 32'h0000_0000, 32'(pad_oe));
		@(posedge clk);
		core_ok <= 1'h1;
		rst_pin_drv <= 1'h0;
		settle(6);
		chk("pin digital reset", 32'h0000_0001, 32'(digital_rst));
		chk("pin analog reset", 32'h0000_0000, 32'(analog_rst));
		chk("reset oe", 32'h0000_0000, 32'(pad_oe));
		@(posedge clk);
		rst_pin_drv <= 1'h1;
		pok_in <= 1'h0;
		settle(6);
		chk("reset pin pull", 32'h0000_0001, 32'(reset_pad_oe));
		chk("reset pin data", 32'h0000_0000, 32'(reset_pad_out));
		chk("poc analog reset", 32'h0000_0001, 32'(analog_rst));
		@(posedge clk);
		pok_in <= 1'h1;
		aon_ok <= 1'h0;
		settle(6);
		chk("power ok aon", 32'h0000_0000, 32'(power_ok_out));
		@(posedge clk);
		aon_ok <= 1'h1;
		scdc_ok <= 1'h0;
		settle(6);
		chk("power ok scdc", 32'h0000_0000, 32'(power_ok_out));
		@(posedge clk);
		scdc_ok <= 1'h1;
		settle(6);
		chk("power back", 32'h0000_0003, {30'h0, pad_oe[3], power_ok_out});
		$display("test power pins done");

		for (int i = 0; i < 4; i++) begin
			wr(pad_pkg::OFF_PAD_CFG + 8'h08, cfg(2'h2, 2'(i), i[0], 1'h0, 2'(i), ~i[0]));
			settle(3);
			chk("pad2 elec", {26'h0, 2'(i), i[0], 2'(i), ~i[0]}, 32'(pad_elec[2]));
			rd(pad_pkg::OFF_PAD_CFG + 8'h08, rdv);
			chk("pad2 cfg", cfg(2'h2, 2'(i), i[0], 1'h0, 2'(i), ~i[0]), rdv);
		end
		chk("aon vsel", 32'h0000_0002, 32'(aon_pad_vsel));
		rd(pad_pkg::OFF_AON_CFG, rdv);
		chk("aon cfg", 32'h0000_000B, rdv);
		$display("test electrical done");

		wr(pad_pkg::OFF_PAD_CFG + 8'h0C, cfg(2'h0, 2'h0, 1'h0, 1'h1, 2'h0, 1'h0));
		settle(3);
		chk("od out", 32'h0000_0001, {31'h0, pad_oe[3] & ~pad_out[3]});
		@(posedge clk);
		sz_drv <= '{out: 8'hFF, oe: 8'h00};
		settle(3);
		chk("od release", 32'h0000_0000, 32'(pad_oe[3]));
		$display("test open drain done");

		@(posedge clk);
		lp_drv <= DRV_IDLE;
		antenna_select <= 3'h5;
		wr(pad_pkg::OFF_CTRL, 32'h0000_0001);
		settle(3);
		chk("antenna out", 32'h0000_0021, 32'(pad_out & pad_pkg::ANT_PAD_MASK));
		chk("antenna oe", 32'h0000_0031, 32'(pad_oe & pad_pkg::ANT_PAD_MASK));
		wr(pad_pkg::OFF_CTRL, 32'h0000_0000);
		settle(3);
		chk("gpio oe", 32'h0000_0000, 32'(pad_oe & pad_pkg::ANT_PAD_MASK));
		$display("test antenna done");
		complete_run();
	end
endmodule
